// file: rtl/sodc_pkg.sv
// package: constants and carrier types for the octal driver serial control block
package sodc_pkg;
	localparam int unsigned CHANNELS        = 8;
	localparam int unsigned CNT_W           = 3;
	localparam int unsigned CLK_PERIOD_NS   = 10;
	// settling time after a direct-drive transition, least figure
	localparam int unsigned SETTLE_TIME_US  = 15;
	localparam int unsigned SETTLE_CYCLES   = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  LATCH_RESET     = 8'h00;
	localparam logic [7:0]  FAULT_RESET     = 8'h00;
	localparam logic [2:0]  CNT_RESET       = 3'h0;
	localparam int unsigned OC_LAST         = 5;
	localparam logic [7:0]  DIRECT_MASK     = 8'h03;
	localparam logic [7:0]  RESET_CLR_MASK  = 8'h06;

	// serial pins after synchronisation
	typedef struct packed {
		logic sck;
		logic sel_n;
		logic mosi;
	} sodc_link_s;

	// analog-side sense per channel
	typedef struct packed {
		logic [7:0] over_sat;
		logic [7:0] comp_above;
		logic [7:0] over_temp;
	} sodc_sense_s;
endpackage : sodc_pkg

// file: rtl/sodc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sodc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// data
	input  wire logic [WIDTH-1:0] i_async,
	input  wire logic [WIDTH-1:0] i_reset_val,
	output var  logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			// idle levels, so no false edge is seen after reset
			meta_reg <= i_reset_val;
			o_sync   <= i_reset_val;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : sodc_sync
`default_nettype wire

// file: rtl/sodc_top.sv
// serial control, output latch and fault latches of the octal low side driver
`timescale 1ns/1ns
`default_nettype none
module sodc_top
	import sodc_pkg::*;
#(
	parameter int unsigned SETTLE_CNT = SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	// device reset sources
	input  wire logic              i_reset_pin_n,
	input  wire logic              i_low_supply_reset,
	// serial link pins
	input  wire logic              i_sck,
	input  wire logic              i_sel_n,
	input  wire logic              i_mosi,
	output var  logic              o_miso,
	output var  logic              o_miso_oe,
	// direct drive pins for channels zero and one
	input  wire logic              i_direct_drive_zero,
	input  wire logic              i_direct_drive_one,
	// analog sense per channel
	input  wire sodc_sense_s       i_sense,
	// channel outputs and state
	output var  logic [7:0]        o_power_output_channel,
	output var  logic [7:0]        o_channel_control_bits,
	output var  logic [7:0]        o_fault_latched
);
	// sck, sel_n, mosi, two direct drives, reset pin, supply reset
	localparam int unsigned SW = 7;
	// select and reset pin idle high, all others low
	localparam logic [SW-1:0] SYNC_RST = 7'h22;

	logic [SW-1:0] sync_w;
	sodc_link_s    link;
	logic          dd0;
	logic          dd1;
	logic          dev_rst;

	sodc_sync #(.WIDTH(SW)) u_sync (
		.i_clk       (i_clk),
		.i_rstn      (i_rstn),
		.i_async     ({i_sck, i_sel_n, i_mosi, i_direct_drive_zero, i_direct_drive_one,
		               i_reset_pin_n, i_low_supply_reset}),
		.i_reset_val (SYNC_RST),
		.o_sync      (sync_w)
	);

	assign link    = sync_w[6:4];
	assign dd0     = sync_w[3];
	assign dd1     = sync_w[2];
	assign dev_rst = !sync_w[1] || sync_w[0];

	// edge detection on synchronised link signals
	logic sck_d_reg;
	logic sel_d_reg;
	logic sck_rise;
	logic sck_fall;
	logic sel_fall;
	logic sel_rise;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sck_d_reg <= 1'b0;
			sel_d_reg <= 1'b1;
		end else begin
			sck_d_reg <= link.sck;
			sel_d_reg <= link.sel_n;
		end
	end

	// clock edges count only while selected
	assign sck_rise = link.sck && !sck_d_reg && !link.sel_n;
	assign sck_fall = !link.sck && sck_d_reg && !link.sel_n;
	assign sel_fall = !link.sel_n && sel_d_reg;
	assign sel_rise = link.sel_n && !sel_d_reg;

	// shift register and output bit
	logic [7:0]       shift_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [7:0]       diag_bits;

	// diagnostic bit n is channel n comparator
	assign diag_bits = i_sense.comp_above;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			shift_reg <= 8'h00;
		end else if (sel_fall) begin
			shift_reg <= diag_bits;
		end else if (sck_fall) begin
			shift_reg <= {shift_reg[6:0], link.mosi};
		end
	end

	// miso shows the msb after select fall, then the shift register msb after each rising clock
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_miso    <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			o_miso_oe <= !link.sel_n;
			if (sel_fall) begin
				o_miso <= diag_bits[7];
			end else if (sck_rise) begin
				o_miso <= shift_reg[7];
			end
		end
	end

	// shift happens on the falling clock, so the msb presented at the rising clock is the
	// bit that was shifted up at the previous fall
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_reg <= CNT_RESET;
		end else if (sel_fall) begin
			cnt_reg <= CNT_RESET;
		end else if (sck_fall) begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

	// output latch
	logic [7:0] latch_reg;

	always_ff @(posedge i_clk) begin
		if (!i_rstn || dev_rst) begin
			latch_reg <= LATCH_RESET;
		end else if (sel_rise && cnt_reg == CNT_RESET) begin
			latch_reg <= shift_reg;
		end
	end

	// commanded state per channel, direct drive ORed on zero and one
	logic [7:0] cmd_on;
	always_comb begin
		cmd_on    = latch_reg;
		cmd_on[0] = latch_reg[0] || dd0;
		cmd_on[1] = latch_reg[1] || dd1;
	end

	// settling blanking for direct channels
	logic [1:0]  dd_d_reg;
	logic [31:0] blank_cnt_reg [2];
	logic [1:0]  blanked;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dd_d_reg <= 2'b00;
		end else begin
			dd_d_reg <= {dd1, dd0};
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_blank
		always_ff @(posedge i_clk) begin
			if (!i_rstn) begin
				blank_cnt_reg[g] <= 32'h0;
			end else if (dd_d_reg[g] != (g == 0 ? dd0 : dd1)) begin
				blank_cnt_reg[g] <= SETTLE_CNT;
			end else if (blank_cnt_reg[g] != 32'h0) begin
				blank_cnt_reg[g] <= blank_cnt_reg[g] - 32'h1;
			end
		end
		// the edge cycle itself is blanked too, before the counter is loaded
		assign blanked[g] = (blank_cnt_reg[g] != 32'h0) || (dd_d_reg[g] != (g == 0 ? dd0 : dd1));
	end

	// fault latches
	logic [7:0] fault_reg;
	logic [7:0] cmd_d_reg;
	logic [7:0] fault_src;
	logic [7:0] rearm;

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			// overcurrent on 0-5, over-temperature on 6-7
			fault_src[i] = cmd_on[i] && ((i <= OC_LAST) ? i_sense.over_sat[i] : i_sense.over_temp[i]);
		end
		fault_src[0] = fault_src[0] && !blanked[0];
		fault_src[1] = fault_src[1] && !blanked[1];
		// off then on again re-arms the channel
		rearm = cmd_on & ~cmd_d_reg;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cmd_d_reg <= 8'h00;
		end else begin
			cmd_d_reg <= cmd_on;
		end
	end

	// a new fault wins over re-arm or release in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			fault_reg <= FAULT_RESET;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (fault_src[i] && !(dev_rst && RESET_CLR_MASK[i])) begin
					fault_reg[i] <= 1'b1;
				end else if (dev_rst && RESET_CLR_MASK[i]) begin
					fault_reg[i] <= 1'b0;
				end else if (rearm[i]) begin
					fault_reg[i] <= 1'b0;
				end else if (!link.sel_n && !i_sense.over_sat[i]) begin
					// release only once the over-saturation sense no longer flags it, over-temperature channels 6-7 included
					fault_reg[i] <= 1'b0;
				end
			end
		end
	end

	// outputs; the control latch is left untouched by a fault
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_power_output_channel <= 8'h00;
			o_channel_control_bits <= 8'h00;
			o_fault_latched        <= 8'h00;
		end else begin
			o_power_output_channel <= dev_rst ? 8'h00 : (cmd_on & ~fault_reg);
			o_channel_control_bits <= latch_reg;
			o_fault_latched        <= fault_reg;
		end
	end
endmodule : sodc_top
`default_nettype wire

// file: bench/sodc_top_sva.sv
// checker: port-level assertions for the serial control block
`timescale 1ns/1ns
`default_nettype none
module sodc_top_sva
	import sodc_pkg::*;
(
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_rstn,
	// reset sources and link
	input wire logic        i_reset_pin_n,
	input wire logic        i_low_supply_reset,
	input wire logic        i_sck,
	input wire logic        i_sel_n,
	input wire logic        i_mosi,
	input wire logic        o_miso,
	input wire logic        o_miso_oe,
	// drive, sense and channel state
	input wire logic        i_direct_drive_zero,
	input wire logic        i_direct_drive_one,
	input wire sodc_sense_s i_sense,
	input wire logic [7:0]  o_power_output_channel,
	input wire logic [7:0]  o_channel_control_bits,
	input wire logic [7:0]  o_fault_latched
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	property p_oe_off; $rose(i_sel_n) |-> ##[1:6] !o_miso_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("serial out still driven after deselect");
	property p_oe_on; $fell(i_sel_n) |-> ##[3:6] o_miso_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("serial out not enabled after select");
	property p_fault_off; (o_fault_latched & $past(o_fault_latched) & o_power_output_channel) == 8'h00; endproperty
	a_fault_off: assert property (p_fault_off) else $error("faulted channel still on");
	property p_pin; !i_reset_pin_n [*5] |-> (o_channel_control_bits | o_power_output_channel) == 8'h00; endproperty
	a_pin: assert property (p_pin) else $error("reset pin did not clear outputs");
	property p_supply; i_low_supply_reset [*5] |-> (o_channel_control_bits | o_power_output_channel) == 8'h00; endproperty
	a_supply: assert property (p_supply) else $error("supply reset did not clear outputs");
	property p_latch; $changed(o_channel_control_bits) && i_reset_pin_n && !i_low_supply_reset |-> i_sel_n; endproperty
	a_latch: assert property (p_latch) else $error("latch changed while selected");
	property p_direct; (i_direct_drive_zero && i_reset_pin_n && !i_low_supply_reset && !o_fault_latched[0]) [*6]
		|-> o_power_output_channel[0]; endproperty
	a_direct: assert property (p_direct) else $error("direct drive did not turn channel on");
	// channel six is the lamp channel that the scenarios drive into over-temperature
	property p_temp; $rose(o_fault_latched[6]) |-> $past(i_sense.over_temp[6]) || $past(i_sense.over_temp[6], 2); endproperty
	a_temp: assert property (p_temp) else $error("lamp channel fault without over-temperature");
	c_fault: cover property ($rose(o_fault_latched[3]));
	c_latch: cover property ($changed(o_channel_control_bits) && i_sel_n);
	c_sel: cover property ($fell(i_sel_n));
endmodule : sodc_top_sva
bind sodc_top sodc_top_sva i_sva (.i_clk, .i_rstn, .i_reset_pin_n, .i_low_supply_reset, .i_sck, .i_sel_n, .i_mosi,
	.o_miso, .o_miso_oe, .i_direct_drive_zero, .i_direct_drive_one, .i_sense, .o_power_output_channel,
	.o_channel_control_bits, .o_fault_latched);
`default_nettype wire

// file: bench/sodc_spi_master.sv
// partner model: serial master, clock idle low, samples on the falling clock
`timescale 1ns/1ns
`default_nettype none
module sodc_spi_master (
	// observed clock and device serial out
	input  wire logic i_clk,
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	// link pins to the device
	output var  logic o_sck = 1'b0,
	output var  logic o_sel_n = 1'b1,
	output var  logic o_mosi = 1'b0
);
	logic last_reg = 1'b0;
	logic miso_w;
	// a floating line shows the inverse of the last bit, so it never matches by luck
	assign miso_w = i_miso_oe ? i_miso : ~last_reg;
	always @(posedge i_clk) begin
		if (i_miso_oe) begin
			last_reg <= i_miso;
		end
	end
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		o_sel_n = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			o_sck = 1'b1;
			o_mosi = tx[7 - (i % 8)];
			#160;
			o_sck = 1'b0;
			rx = {rx[6:0], miso_w};
			#160;
		end
		#160;
		o_sel_n = 1'b1;
		o_mosi = ~o_mosi;
		#400;
	endtask : xfer
endmodule : sodc_spi_master
`default_nettype wire

// file: bench/sodc_top_bench.sv
// self-checking bench for the octal driver serial control block
`timescale 1ns/1ns
`default_nettype none
module sodc_top_bench;
	import sodc_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        pin_n = 1'b1;
	logic        lsr = 1'b0;
	logic        ddz = 1'b0;
	logic        ddo = 1'b0;
	sodc_sense_s sense = 24'h000000;
	wire logic   sck, sel_n, mosi, miso, oe;
	wire logic [7:0] pwr, ctl, flt;
	logic [7:0]  rx;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cycles = 0;
	always #5 clk = ~clk;
	sodc_top #(.SETTLE_CNT(20)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_reset_pin_n(pin_n), .i_low_supply_reset(lsr),
		.i_sck(sck), .i_sel_n(sel_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_direct_drive_zero(ddz),
		.i_direct_drive_one(ddo), .i_sense(sense), .o_power_output_channel(pwr), .o_channel_control_bits(ctl),
		.o_fault_latched(flt));
	sodc_spi_master i_master (.i_clk(clk), .i_miso(miso), .i_miso_oe(oe), .o_sck(sck), .o_sel_n(sel_n), .o_mosi(mosi));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	// the whole sequence needs well under 10000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic t_byte;
		sense.comp_above = 8'h3C;
		i_master.xfer(8'hA5, 8, rx);
		wait_n(10);
		check(rx, 8'h3C);
		check(ctl, 8'hA5);
		check(pwr, 8'hA5);
		check({7'h00, oe}, 8'h00);
	endtask : t_byte
	task automatic t_count;
		i_master.xfer(8'h0F, 7, rx);
		wait_n(10);
		check(ctl, 8'hA5);
		i_master.xfer(8'h5A, 16, rx);
		wait_n(10);
		check(ctl, 8'h5A);
	endtask : t_count
	task automatic t_fault;
		sense.over_sat = 8'h4A;
		wait_n(10);
		check(flt, 8'h0A);
		sense.over_temp = 8'h40;
		wait_n(10);
		check(flt, 8'h4A);
		check(pwr, 8'h10);
		sense = 24'h000000;
		wait_n(10);
		check(flt, 8'h4A);
		check(ctl, 8'h5A);
		pin_n = 1'b0;
		wait_n(10);
		check(ctl | pwr, 8'h00);
		check(flt & RESET_CLR_MASK, 8'h00);
		pin_n = 1'b1;
		wait_n(5);
	endtask : t_fault
	// channels three and six stay off in this byte, so only the select-low release can clear them
	task automatic t_supply;
		i_master.xfer(8'hB4, 8, rx);
		wait_n(10);
		check(ctl, 8'hB4);
		check(flt, 8'h00);
		lsr = 1'b1;
		wait_n(10);
		check(ctl | pwr, 8'h00);
		lsr = 1'b0;
		wait_n(5);
	endtask : t_supply
	// blanking lasts 20 cycles here, so a check after 10 falls inside it and one after 40 beyond it
	task automatic t_direct;
		ddz = 1'b1;
		ddo = 1'b1;
		wait_n(30);
		check(pwr, 8'h03);
		ddz = 1'b0;
		ddo = 1'b0;
		wait_n(30);
		check(pwr, 8'h00);
		ddz = 1'b1;
		sense.over_sat = 8'h01;
		wait_n(10);
		check(flt, 8'h00);
		check(pwr, 8'h01);
		wait_n(30);
		check(flt, 8'h01);
		check(pwr, 8'h00);
		sense.over_sat = 8'h00;
		ddz = 1'b0;
		wait_n(30);
		check(flt, 8'h01);
		ddz = 1'b1;
		wait_n(30);
		check(flt, 8'h00);
		check(pwr, 8'h01);
		ddz = 1'b0;
		wait_n(5);
	endtask : t_direct
	initial begin
		wait_n(3);
		rstn = 1'b1;
		wait_n(5);
		check(ctl | pwr | flt, 8'h00);
		t_byte();
		t_count();
		t_fault();
		t_supply();
		t_direct();
		tally_and_finish();
	end
endmodule : sodc_top_bench
`default_nettype wire
